// ===== rtl/dtw_timer_regs.svh
`ifndef DTW_TIMER_REGS_SVH
`define DTW_TIMER_REGS_SVH
// register offsets on the byte-wide register port
`define OFS_CONTROL_A   6'h00
`define OFS_CONTROL_C   6'h02
`define OFS_CONTROL_D   6'h03
`define OFS_CONTROL_E   6'h04
`define OFS_EVCFG_A     6'h08
`define OFS_EVCFG_B     6'h09
`define OFS_IRQ_ENABLE  6'h0C
`define OFS_IRQ_FLAG    6'h0D
`define OFS_STATUS      6'h0E
`define OFS_INPUT_B     6'h11
`define OFS_FAULT_CFG   6'h12
`define OFS_DELAY_CFG   6'h14
`define OFS_DELAY_VAL   6'h15
`define OFS_SAMPLE_A_LO 6'h22
`define OFS_SAMPLE_A_HI 6'h23
`define OFS_SAMPLE_B_LO 6'h24
`define OFS_SAMPLE_B_HI 6'h25
`define OFS_UNLOCK      6'h30
// compares sit at 0x28..0x2F: bits [2:1] pick the compare, bit 0 the byte
`define CMP_BASE        3'h5
// field positions
`define BIT_RUN_ENABLE  0
`define BIT_OVERRIDE    0
`define BIT_SEL_C       6
`define BIT_SEL_D       7
`define BIT_SW_SAMPLE_A 2
`define BIT_SW_SAMPLE_B 3
`define BIT_EV_ACTION   2
`define BIT_IRQ_CYCLE   0
`define BIT_IRQ_ON_A    2
`define BIT_IRQ_ON_B    3
`define BIT_CMD_READY   1
`define BIT_EN_READY    0
`define BIT_ACT_A       6
`define BIT_ACT_B       7
// compare indices
`define CMP_A_SET       2'h0
`define CMP_A_CLR       2'h1
`define CMP_B_SET       2'h2
`define CMP_B_CLR       2'h3
// encodings and reset values
`define INPUT_MODE_RESTART 4'h8
`define DLY_MODE_BLANK  2'h1
`define DLY_MODE_EVENT  2'h2
`define SLEEP_STANDBY   2'h2
`define CMP_B_CLR_RESET 12'hFFF
`define UNLOCK_WINDOW   3'h4
`endif

// ===== rtl/dtw_timer_pkg.sv
package dtw_timer_pkg;
   // the four counter phases of one single-ramp cycle
   typedef enum logic [1:0] {DEAD_A, ON_A, DEAD_B, ON_B} phase_t;
   // state of the output-event delay
   typedef enum logic {DLY_IDLE, DLY_COUNT} dly_state_t;
endpackage

// ===== rtl/dead_time_waveform_timer.sv
`timescale 1ns/1ps
`include "dtw_timer_regs.svh"
module dead_time_waveform_timer #(
   parameter int         CNT_W      = 12,
   parameter logic [7:0] UNLOCK_KEY = 8'hA5  // arbitrary key value
) (
   input  wire logic       MCLK,
   input  wire logic       RSTN,
   input  wire logic       SYS_RESET,
   input  wire logic [7:0] FUSE_CFG,
   input  wire logic [1:0] SLEEP_MODE,
   input  wire logic       FAULT_IN,
   input  wire logic       EV_IN_A,
   input  wire logic       EV_IN_B,
   input  wire logic [5:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   output logic            WO_A,
   output logic            WO_B,
   output logic            WO_C,
   output logic            WO_D,
   output logic      [3:0] WO_OE,
   output logic            EV_OUT_B_CLR,
   output logic            EV_OUT_A_SET,
   output logic            EV_OUT_B_SET,
   output logic            EV_OUT_PROG,
   output logic            IRQ_CYCLE_END,
   output logic            IRQ_ON_TIME
);
   logic             [7:0] control_a;
   logic             [7:0] control_c_reg;
   logic             [7:0] control_d_reg;
   logic             [7:0] event_input_config [2];
   logic             [7:0] irq_enable_reg;
   logic             [7:0] irq_flag_reg;
   logic             [3:0] input_b_mode_reg;
   logic             [7:0] output_fault_config;
   logic             [7:0] delay_config_reg;
   logic             [7:0] delay_count_value;
   logic         [CNT_W-1:0] cmp [4];
   logic         [CNT_W-1:0] cnt;
   logic         [CNT_W-1:0] sample_reg_a;
   logic         [CNT_W-1:0] sample_reg_b;
   logic             [3:0] sample_hi_tmp;
   logic             [1:0] sw_pend;
   logic                   fuse_load;
   logic             [2:0] unlock_guard;
   logic             [7:0] dly_cnt;
   logic             [2:0] presc_cnt;
   logic                   dly_tick;
   dtw_timer_pkg::dly_state_t dly_state;
   dtw_timer_pkg::phase_t phase;
   logic             [7:0] next_rdata;
   logic                   run;
   logic                   cycle_end;
   logic             [3:0] match;
   logic             [1:0] cap_req;
   logic                   prog_on_time_entry_irq;
   logic                   next_wo_a;
   logic                   next_wo_b;
   logic             [1:0] delay_select;
   logic             [1:0] delay_source_select;
   logic             [1:0] delay_prescaler;
   logic                   command_ready_bit;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);

   function automatic logic hit(input logic [5:0] ofs);
      hit = WR && (ADDR == ofs);
   endfunction

   // phase of the single-ramp cycle for a given counter value
   function automatic dtw_timer_pkg::phase_t phase_of(input logic [CNT_W-1:0] c);
      if (c < cmp[`CMP_A_SET])
         phase_of = dtw_timer_pkg::DEAD_A;
      else if (c < cmp[`CMP_A_CLR])
         phase_of = dtw_timer_pkg::ON_A;
      else if (c < cmp[`CMP_B_SET])
         phase_of = dtw_timer_pkg::DEAD_B;
      else
         phase_of = dtw_timer_pkg::ON_B;
   endfunction

   assign delay_select        = delay_config_reg[1:0];
   assign delay_source_select = delay_config_reg[3:2];
   assign delay_prescaler     = delay_config_reg[5:4];
   assign command_ready_bit   = ~|sw_pend;
   // standby and power-down freeze the counter; idle keeps it going
   assign run = control_a[`BIT_RUN_ENABLE] && (SLEEP_MODE < `SLEEP_STANDBY);
   assign cycle_end = run && (cnt == cmp[`CMP_B_CLR]);
   // each unit has its own event input and software strobe
   assign cap_req[0] = (EV_IN_A && event_input_config[0][`BIT_EV_ACTION]) || sw_pend[0];
   assign cap_req[1] = (EV_IN_B && event_input_config[1][`BIT_EV_ACTION]) || sw_pend[1];

   // compare matches, only while counting
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         match[i] = run && (cnt == cmp[i]);
   end

   // software registers; a soft reset puts them back, and fault config reloads from the fuses
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         control_a <= 8'h00;
         control_c_reg <= 8'h00;
         control_d_reg <= 8'h00;
         event_input_config[0] <= 8'h00;
         event_input_config[1] <= 8'h00;
         irq_enable_reg <= 8'h00;
         input_b_mode_reg <= 4'h0;
         delay_config_reg <= 8'h00;
         delay_count_value <= 8'h00;
         cmp[0] <= '0;
         cmp[1] <= '0;
         cmp[2] <= '0;
         cmp[3] <= `CMP_B_CLR_RESET;
      end
      else if (SYS_RESET)
      begin
         control_a <= 8'h00;
         control_c_reg <= 8'h00;
         control_d_reg <= 8'h00;
         event_input_config[0] <= 8'h00;
         event_input_config[1] <= 8'h00;
         irq_enable_reg <= 8'h00;
         input_b_mode_reg <= 4'h0;
         delay_config_reg <= 8'h00;
         delay_count_value <= 8'h00;
         cmp[0] <= '0;
         cmp[1] <= '0;
         cmp[2] <= '0;
         cmp[3] <= `CMP_B_CLR_RESET;
      end
      else
      begin
         if (hit(`OFS_CONTROL_A))
            control_a <= WDATA;
         if (hit(`OFS_CONTROL_C))
            control_c_reg <= WDATA;
         if (hit(`OFS_CONTROL_D))
            control_d_reg <= WDATA;
         if (hit(`OFS_EVCFG_A))
            event_input_config[0] <= WDATA;
         if (hit(`OFS_EVCFG_B))
            event_input_config[1] <= WDATA;
         if (hit(`OFS_IRQ_ENABLE))
            irq_enable_reg <= WDATA;
         if (hit(`OFS_INPUT_B))
            input_b_mode_reg <= WDATA[3:0];
         if (hit(`OFS_DELAY_CFG))
            delay_config_reg <= WDATA;
         if (hit(`OFS_DELAY_VAL))
            delay_count_value <= WDATA;
         // 12-bit compares written byte by byte, high nibble in the odd byte
         if (WR && ADDR[5:3] == `CMP_BASE)
         begin
            if (ADDR[0])
               cmp[ADDR[2:1]][CNT_W-1:8] <= WDATA[CNT_W-9:0];
            else
               cmp[ADDR[2:1]][7:0] <= WDATA;
         end
      end
   end

   // unlock window: key opens four cycles for a protected write
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         unlock_guard <= 3'h0;
      else if (hit(`OFS_UNLOCK) && WDATA == UNLOCK_KEY)
         unlock_guard <= `UNLOCK_WINDOW;
      else if (unlock_guard != 3'h0)
         unlock_guard <= unlock_guard - 3'h1;
   end

   // fault config: zero only at power-on, fuse value after every reset
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         output_fault_config <= 8'h00;
         fuse_load <= 1'b1;
      end
      else
      begin
         fuse_load <= 1'b0;
         if (fuse_load || SYS_RESET)
            output_fault_config <= FUSE_CFG;
         else if (hit(`OFS_FAULT_CFG) && unlock_guard != 3'h0)
            output_fault_config <= WDATA;
      end
   end

   // counter; input B in restart mode wraps it as well as capturing
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         cnt <= '0;
      else if (SYS_RESET)
         cnt <= '0;
      else if (run && EV_IN_B && input_b_mode_reg == `INPUT_MODE_RESTART)
         cnt <= '0;
      else if (cycle_end)
         cnt <= '0;
      else if (run)
         cnt <= cnt + CNT_W'(1);
   end

   // sample units; software strobes wait one cycle so command ready is seen low
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         sample_reg_a <= '0;
         sample_reg_b <= '0;
         sw_pend <= 2'b00;
      end
      else
      begin
         if (cap_req[0])
            sample_reg_a <= cnt;
         if (cap_req[1])
            sample_reg_b <= cnt;
         sw_pend[0] <= hit(`OFS_CONTROL_E) && WDATA[`BIT_SW_SAMPLE_A];
         sw_pend[1] <= hit(`OFS_CONTROL_E) && WDATA[`BIT_SW_SAMPLE_B];
      end
   end

   // high nibble frozen when the low byte is read, so the pair stays coherent
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         sample_hi_tmp <= 4'h0;
      else if (RD && ADDR == `OFS_SAMPLE_A_LO)
         sample_hi_tmp <= sample_reg_a[CNT_W-1:8];
      else if (RD && ADDR == `OFS_SAMPLE_B_LO)
         sample_hi_tmp <= sample_reg_b[CNT_W-1:8];
   end

   // flags: hardware set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         irq_flag_reg <= 8'h00;
      else if (SYS_RESET)
         irq_flag_reg <= 8'h00;
      else
      begin
         if (hit(`OFS_IRQ_FLAG))
            irq_flag_reg <= irq_flag_reg & ~WDATA;
         if (cycle_end)
            irq_flag_reg[`BIT_IRQ_CYCLE] <= 1'b1;
         if (cap_req[0] || match[`CMP_A_SET])
            irq_flag_reg[`BIT_IRQ_ON_A] <= 1'b1;
         if (cap_req[1] || match[`CMP_B_SET])
            irq_flag_reg[`BIT_IRQ_ON_B] <= 1'b1;
      end
   end

   // interrupt lines are levels; on-time A and B share one line
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         IRQ_CYCLE_END <= 1'b0;
         IRQ_ON_TIME <= 1'b0;
      end
      else
      begin
         IRQ_CYCLE_END <= irq_flag_reg[`BIT_IRQ_CYCLE] && irq_enable_reg[`BIT_IRQ_CYCLE];
         IRQ_ON_TIME <= |(irq_flag_reg[`BIT_IRQ_ON_B:`BIT_IRQ_ON_A]
                          & irq_enable_reg[`BIT_IRQ_ON_B:`BIT_IRQ_ON_A]);
      end
   end

   // waveform levels per phase; override takes its bit from the phase value field
   always_comb
   begin
      next_wo_a = (phase == dtw_timer_pkg::ON_A);
      next_wo_b = (phase == dtw_timer_pkg::ON_B);
      if (control_c_reg[`BIT_OVERRIDE])
      begin
         next_wo_a = control_d_reg[{1'b0, phase}];
         next_wo_b = control_d_reg[{1'b1, phase}];
      end
      if (FAULT_IN)
      begin
         next_wo_a = output_fault_config[0];
         next_wo_b = output_fault_config[1];
      end
   end

   // outputs registered; a disabled output is released and held low
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         phase <= dtw_timer_pkg::DEAD_A;
         WO_A <= 1'b0;
         WO_B <= 1'b0;
         WO_C <= 1'b0;
         WO_D <= 1'b0;
         WO_OE <= 4'h0;
      end
      else
      begin
         phase <= phase_of(cnt);
         WO_OE <= output_fault_config[7:4];
         WO_A <= output_fault_config[4] && next_wo_a;
         WO_B <= output_fault_config[5] && next_wo_b;
         // fault levels of C and D are their own bits, not those of A or B
         WO_C <= output_fault_config[6] && (FAULT_IN ? output_fault_config[2] :
                 (control_c_reg[`BIT_SEL_C] ? next_wo_b : next_wo_a));
         WO_D <= output_fault_config[7] && (FAULT_IN ? output_fault_config[3] :
                 (control_c_reg[`BIT_SEL_D] ? next_wo_b : next_wo_a));
      end
   end

   // match strobes, one counter-clock cycle each
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         EV_OUT_B_CLR <= 1'b0;
         EV_OUT_A_SET <= 1'b0;
         EV_OUT_B_SET <= 1'b0;
      end
      else
      begin
         EV_OUT_B_CLR <= match[`CMP_B_CLR];
         EV_OUT_A_SET <= match[`CMP_A_SET];
         EV_OUT_B_SET <= match[`CMP_B_SET];
      end
   end

   assign prog_on_time_entry_irq = match[delay_source_select];

   // delay clock: divider restarts with each trigger, so the delay is exact, not off by a phase
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         presc_cnt <= 3'h0;
      else if (dly_state == dtw_timer_pkg::DLY_IDLE)
         presc_cnt <= 3'h0;
      else
         presc_cnt <= presc_cnt + 3'h1;
   end

   // one-cycle enable on the last sync cycle of every 2^prescaler
   assign dly_tick = &(presc_cnt | ~((3'h1 << delay_prescaler) - 3'h1));

   // programmable event; a trigger while counting is dropped to keep one pending
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         dly_state <= dtw_timer_pkg::DLY_IDLE;
         dly_cnt <= 8'h00;
         EV_OUT_PROG <= 1'b0;
      end
      else
      begin
         EV_OUT_PROG <= 1'b0;
         unique case (dly_state)
            dtw_timer_pkg::DLY_IDLE:
               if (prog_on_time_entry_irq)
               begin
                  if (delay_select == `DLY_MODE_EVENT && delay_count_value != 8'h00)
                  begin
                     dly_state <= dtw_timer_pkg::DLY_COUNT;
                     dly_cnt <= 8'h00;
                  end
                  else
                     EV_OUT_PROG <= 1'b1;
               end
            dtw_timer_pkg::DLY_COUNT:
               if (delay_select != `DLY_MODE_EVENT)
                  dly_state <= dtw_timer_pkg::DLY_IDLE;
               else if (dly_tick)
               begin
                  if (dly_cnt + 8'h01 >= delay_count_value)
                  begin
                     EV_OUT_PROG <= 1'b1;
                     dly_state <= dtw_timer_pkg::DLY_IDLE;
                  end
                  dly_cnt <= dly_cnt + 8'h01;
               end
         endcase
      end
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      next_rdata = 8'h00;
      if (ADDR[5:3] == `CMP_BASE)
         next_rdata = ADDR[0] ? {4'h0, cmp[ADDR[2:1]][CNT_W-1:8]} : cmp[ADDR[2:1]][7:0];
      else
         unique case (ADDR)
            `OFS_CONTROL_A: next_rdata = control_a;
            `OFS_CONTROL_C: next_rdata = control_c_reg;
            `OFS_CONTROL_D: next_rdata = control_d_reg;
            `OFS_EVCFG_A: next_rdata = event_input_config[0];
            `OFS_EVCFG_B: next_rdata = event_input_config[1];
            `OFS_IRQ_ENABLE: next_rdata = irq_enable_reg;
            `OFS_IRQ_FLAG: next_rdata = irq_flag_reg;
            `OFS_STATUS: next_rdata = {WO_B, WO_A, 4'h0, command_ready_bit, 1'b1};
            `OFS_INPUT_B: next_rdata = {4'h0, input_b_mode_reg};
            `OFS_FAULT_CFG: next_rdata = output_fault_config;
            `OFS_DELAY_CFG: next_rdata = delay_config_reg;
            `OFS_DELAY_VAL: next_rdata = delay_count_value;
            `OFS_SAMPLE_A_LO: next_rdata = sample_reg_a[7:0];
            `OFS_SAMPLE_B_LO: next_rdata = sample_reg_b[7:0];
            `OFS_SAMPLE_A_HI,
            `OFS_SAMPLE_B_HI: next_rdata = {4'h0, sample_hi_tmp};
            default: next_rdata = 8'h00;
         endcase
   end

   // read data only in the cycle after the strobe
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         RDATA <= 8'h00;
      else
         RDATA <= RD ? next_rdata : 8'h00;
   end

   sequence sw_strobe_a;
      hit(`OFS_CONTROL_E) && WDATA[`BIT_SW_SAMPLE_A] && !SYS_RESET;
   endsequence
   sequence busy_then_ready;
      ##1 !command_ready_bit ##1 command_ready_bit;
   endsequence

   a_capture_value: assert property (cap_req[0] |=> sample_reg_a == $past(cnt))
      else $error("sample A does not hold counter at capture");
   a_no_action_hold: assert property (EV_IN_A && !event_input_config[0][`BIT_EV_ACTION]
      && !sw_pend[0] |=> $stable(sample_reg_a))
      else $error("sample A changed without action bit");
   a_capture_flag: assert property (cap_req[1] && !SYS_RESET |=> irq_flag_reg[`BIT_IRQ_ON_B])
      else $error("capture B did not raise its flag");
   a_sw_ready: assert property (sw_strobe_a |-> busy_then_ready)
      else $error("command ready did not drop and return");
   a_ramp_restart: assert property (run && EV_IN_B && !SYS_RESET
      && input_b_mode_reg == `INPUT_MODE_RESTART |=> cnt == '0)
      else $error("input B did not restart counter");
   a_fault_locked: assert property (hit(`OFS_FAULT_CFG) && unlock_guard == 3'h0
      && !SYS_RESET && !fuse_load |=> $stable(output_fault_config))
      else $error("locked fault config changed");
   a_irq_level: assert property (|(irq_flag_reg[`BIT_IRQ_ON_B:`BIT_IRQ_ON_A]
      & irq_enable_reg[`BIT_IRQ_ON_B:`BIT_IRQ_ON_A])
      |=> IRQ_ON_TIME)
      else $error("on-time request missing");
   a_sleep_stop: assert property (SLEEP_MODE >= `SLEEP_STANDBY && !SYS_RESET
      |=> $stable(cnt))
      else $error("counter moved in deep sleep");
   a_fault_level: assert property (FAULT_IN && output_fault_config[4]
      |=> WO_A == $past(output_fault_config[0]))
      else $error("output A not at fault level");
   a_prog_pulse: assert property (EV_OUT_PROG |=> !EV_OUT_PROG)
      else $error("programmable strobe longer than one cycle");
endmodule

// ===== verification/event_network.sv
`timescale 1ns/1ps
// far-side event routing: a request level becomes one strobe per rise
module event_network (
   input  wire logic       clk,
   input  wire logic [1:0] req,
   output logic            ev_a = 1'b0,
   output logic            ev_b = 1'b0
);
   logic [1:0] req_q = 2'h0;
   // edge detect, so a long request never repeats the event
   always @(posedge clk)
   begin
      req_q <= req;
      ev_a  <= req[0] & ~req_q[0];
      ev_b  <= req[1] & ~req_q[1];
   end
endmodule

// ===== verification/dead_time_waveform_timer_bench.sv
`timescale 1ns/1ps
`include "dtw_timer_regs.svh"
module dead_time_waveform_timer_bench;
   localparam logic [7:0] FUSE = 8'h35;
   logic       MCLK = 1'b0;
   logic       RSTN = 1'b0;
   logic       SYS_RESET = 1'b0;
   logic [1:0] SLEEP_MODE = 2'h0;
   logic       FAULT_IN = 1'b0;
   logic [5:0] ADDR = 6'h00;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic [1:0] ev_req = 2'h0;
   logic       ev_a;
   logic       ev_b;
   logic [7:0] RDATA;
   logic       WO_A, WO_B, WO_C, WO_D;
   logic [3:0] WO_OE;
   logic       EV_OUT_B_CLR, EV_OUT_A_SET, EV_OUT_B_SET, EV_OUT_PROG;
   logic       IRQ_CYCLE_END, IRQ_ON_TIME;
   logic [7:0] d;
   logic [11:0] va, vb, g0, g1, g2;
   logic [11:0] cnt [6];
   int         err_total = 0;
   int         samples_checked = 0;

   // 25 MHz clock
   always #20 MCLK = ~MCLK;

   event_network net (.clk(MCLK), .req(ev_req), .ev_a(ev_a), .ev_b(ev_b));

   dead_time_waveform_timer dut (
      .MCLK(MCLK), .RSTN(RSTN), .SYS_RESET(SYS_RESET), .FUSE_CFG(FUSE),
      .SLEEP_MODE(SLEEP_MODE), .FAULT_IN(FAULT_IN), .EV_IN_A(ev_a), .EV_IN_B(ev_b),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .WO_A(WO_A), .WO_B(WO_B), .WO_C(WO_C), .WO_D(WO_D), .WO_OE(WO_OE),
      .EV_OUT_B_CLR(EV_OUT_B_CLR), .EV_OUT_A_SET(EV_OUT_A_SET),
      .EV_OUT_B_SET(EV_OUT_B_SET), .EV_OUT_PROG(EV_OUT_PROG),
      .IRQ_CYCLE_END(IRQ_CYCLE_END), .IRQ_ON_TIME(IRQ_ON_TIME));

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge MCLK);
      ADDR  <= a;
      WDATA <= v;
      WR    <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(posedge MCLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      @(negedge MCLK);
      v = RDATA;
   endtask

   task automatic wr12(input logic [5:0] a, input logic [11:0] v);
      wr(a, v[7:0]);
      wr(a + 6'h01, {4'h0, v[11:8]});
   endtask

   task automatic unlocked_fault(input logic [7:0] v);
      wr(`OFS_UNLOCK, 8'hA5);
      wr(`OFS_FAULT_CFG, v);
   endtask

   // software sample of unit u, low byte read first
   task automatic cap(input logic u, output logic [11:0] v);
      logic [7:0] s, lo;
      wr(`OFS_CONTROL_E, u ? 8'h08 : 8'h04);
      for (int i = 0; i < 20; i++)
      begin
         rd(`OFS_STATUS, s);
         if (s[`BIT_CMD_READY] === 1'b1) break;
      end
      chk(s[`BIT_CMD_READY], 1'b1);
      rd(u ? `OFS_SAMPLE_B_LO : `OFS_SAMPLE_A_LO, lo);
      rd(u ? `OFS_SAMPLE_B_HI : `OFS_SAMPLE_A_HI, s);
      v = {s[3:0], lo};
   endtask

   task automatic ev(input int u);
      @(posedge MCLK);
      ev_req[u] <= 1'b1;
      repeat (2) @(posedge MCLK);
      ev_req <= 2'h0;
      repeat (3) @(posedge MCLK);
   endtask

   // cycles from a B clear match strobe to the programmable strobe
   task automatic gap(output logic [11:0] g);
      @(negedge MCLK);
      for (int i = 0; i < 300 && EV_OUT_B_CLR !== 1'b1; i++) @(negedge MCLK);
      for (g = 0; g < 300 && EV_OUT_PROG !== 1'b1; g++) @(negedge MCLK);
      @(negedge MCLK);
      chk(EV_OUT_PROG, 1'b0);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // watchdog well above the expected run length
   initial
   begin
      #(40 * 30000);
      err_total++;
      end_of_test();
   end

   // main sequence
   initial
   begin
      repeat (4) @(posedge MCLK);
      RSTN <= 1'b1;
      repeat (2) @(posedge MCLK);
      rd(`OFS_FAULT_CFG, d); chk(d, FUSE);
      chk(WO_OE, FUSE[7:4]);
      rd(6'h3F, d); chk(d, 8'h00);
      wr(`OFS_FAULT_CFG, 8'hF5);
      rd(`OFS_FAULT_CFG, d); chk(d, FUSE);
      unlocked_fault(8'hF5);
      rd(`OFS_FAULT_CFG, d); chk(d, 8'hF5);
      wr(`OFS_UNLOCK, 8'hA5);
      repeat (6) @(posedge MCLK);
      wr(`OFS_FAULT_CFG, 8'h00);
      rd(`OFS_FAULT_CFG, d); chk(d, 8'hF5);
      @(posedge MCLK);
      SYS_RESET <= 1'b1;
      @(posedge MCLK);
      SYS_RESET <= 1'b0;
      rd(`OFS_FAULT_CFG, d); chk(d, FUSE);
      $display("test fault_config done");
      wr(`OFS_INPUT_B, 8'h08);
      wr(`OFS_EVCFG_B, 8'h04);
      wr(`OFS_CONTROL_A, 8'h01);
      repeat (100) @(posedge MCLK);
      ev(1);
      cap(1'b0, va);
      chk(va < 12'd20, 1'b1);
      wr(`OFS_INPUT_B, 8'h00);
      $display("test restart done");
      unlocked_fault(8'hF5);
      wr12(6'h28, 12'h010);
      wr12(6'h2A, 12'h020);
      wr12(6'h2C, 12'h030);
      wr12(6'h2E, 12'h040);
      @(negedge MCLK);
      for (int i = 0; i < 5000 && EV_OUT_B_CLR !== 1'b1; i++) @(negedge MCLK);
      cnt = '{default: 12'h000};
      repeat (65)
      begin
         @(negedge MCLK);
         cnt[0] += 12'(EV_OUT_A_SET);
         cnt[1] += 12'(EV_OUT_B_SET);
         cnt[2] += 12'(EV_OUT_B_CLR);
         cnt[3] += 12'(WO_A & WO_B);
         cnt[4] += 12'(WO_A);
         cnt[5] += 12'(WO_B);
      end
      for (int i = 0; i < 4; i++) chk(cnt[i], i < 3 ? 12'h001 : 12'h000);
      chk(cnt[4], 12'd16);
      chk(cnt[5], 12'd17);
      $display("test events done");
      @(posedge MCLK);
      SLEEP_MODE <= 2'h2;
      cap(1'b0, va);
      cap(1'b1, vb);
      chk(vb, va);
      @(posedge MCLK);
      SLEEP_MODE <= 2'h1;
      cap(1'b0, va);
      cap(1'b1, vb);
      chk(vb != va, 1'b1);
      @(posedge MCLK);
      SLEEP_MODE <= 2'h0;
      $display("test sleep done");
      wr(`OFS_CONTROL_A, 8'h00);
      wr(`OFS_IRQ_FLAG, 8'hFF);
      ev(0);
      rd(`OFS_IRQ_FLAG, d); chk(d[`BIT_IRQ_ON_A], 1'b0);
      wr(`OFS_EVCFG_A, 8'h04);
      ev(0);
      ev(1);
      rd(`OFS_IRQ_FLAG, d); chk(d[3:2], 2'h3);
      $display("test event_capture done");
      wr(`OFS_IRQ_FLAG, 8'hFF);
      wr(`OFS_CONTROL_A, 8'h01);
      wr(`OFS_IRQ_ENABLE, 8'h01);
      for (int i = 0; i < 200 && IRQ_CYCLE_END !== 1'b1; i++) @(negedge MCLK);
      repeat (20) @(negedge MCLK);
      chk(IRQ_CYCLE_END, 1'b1);
      wr(`OFS_IRQ_FLAG, 8'h01);
      repeat (2) @(negedge MCLK);
      chk(IRQ_CYCLE_END, 1'b0);
      wr(`OFS_IRQ_ENABLE, 8'h0C);
      for (int i = 0; i < 200 && IRQ_ON_TIME !== 1'b1; i++) @(negedge MCLK);
      chk(IRQ_ON_TIME, 1'b1);
      wr(`OFS_IRQ_ENABLE, 8'h00);
      repeat (3) @(negedge MCLK);
      chk(IRQ_ON_TIME, 1'b0);
      $display("test irq done");
      wr(`OFS_DELAY_VAL, 8'h00);
      wr(`OFS_DELAY_CFG, 8'h0E);
      gap(g0);
      wr(`OFS_DELAY_VAL, 8'h08);
      gap(g1); chk(g1 - g0, 12'd8);
      wr(`OFS_DELAY_CFG, 8'h1E);
      gap(g2); chk(g2 - g0, 12'd16);
      wr(`OFS_DELAY_CFG, 8'h0D);
      gap(g2); chk(g2, g0);
      $display("test delay done");
      unlocked_fault(8'hF9);
      wr(`OFS_CONTROL_C, 8'h41);
      wr(`OFS_CONTROL_D, 8'h0F);
      repeat (4)
      begin
         repeat (17) @(negedge MCLK);
         chk({WO_D, WO_C, WO_B, WO_A}, 4'h9);
      end
      wr(`OFS_CONTROL_D, 8'hF0);
      repeat (3) @(negedge MCLK);
      chk({WO_D, WO_C, WO_B, WO_A}, 4'h6);
      @(posedge MCLK);
      FAULT_IN <= 1'b1;
      repeat (3) @(negedge MCLK);
      chk({WO_D, WO_C, WO_B, WO_A}, 4'h9);
      $display("test outputs done");
      end_of_test();
   end
endmodule
